// [core/bdr_cfg.svh]
`ifndef BDR_CFG_SVH
`define BDR_CFG_SVH

// ****************************************
// timing
// ****************************************
`define BDR_CLK_NS 20
`define BDR_CLK_KHZ 50000
`define BDR_WDOG_MS 1600
`define BDR_HOLD_MS 200
`define BDR_WDOG_CYC (`BDR_WDOG_MS * `BDR_CLK_KHZ)
`define BDR_HOLD_CYC (`BDR_HOLD_MS * `BDR_CLK_KHZ)
`define BDR_IO_NS 70
`define BDR_WDR_NS 100
`define BDR_IO_CYC ((`BDR_IO_NS + `BDR_CLK_NS - 1) / `BDR_CLK_NS)
`define BDR_WDR_CYC ((`BDR_WDR_NS + `BDR_CLK_NS - 1) / `BDR_CLK_NS)

// ****************************************
// register byte addresses
// ****************************************
`define BDR_WDR_ADDR 32'h03100000
`define BDR_WDE_ADDR 32'h03100004
`define BDR_IRQ6_ADDR 32'h03180000
`define BDR_IRQ7_ADDR 32'h03180004
`define BDR_IRQ45_ADDR 32'h03180008
`define BDR_NMI_ADDR 32'h0318000C
`define BDR_SRST_ADDR 32'h03200000
`define BDR_ID_ADDR 32'h03200004
`define BDR_BOOT_ADDR 32'h03200008
`define BDR_CFG_ADDR 32'h0320000C

// ****************************************
// reset values and fields
// ****************************************
`define BDR_WDE_RST 4'h0
`define BDR_IRQ6_RST 4'h0
`define BDR_IRQ7_RST 4'h2
`define BDR_IRQ4_RST 4'h4
`define BDR_IRQ5_RST 4'h5
`define BDR_NMI_RST 4'hF
`define BDR_SRST_RST 4'h0
`define BDR_CFG_RST 4'h0
`define BDR_WDE_EN_BIT 0
`define BDR_WDE_CHIP_BIT 1
`define BDR_CFG_EXT_MEM_BIT 0
`define BDR_BOOT_RAW0 4'h0
`define BDR_BOOT_RAW1 4'h1
`define BDR_BOOT_RAW2 4'h2
`define BDR_BOOT_OUT0 4'h5
`define BDR_BOOT_OUT1 4'h7
`define BDR_BOOT_OUT2 4'hD

// ****************************************
// decoded regions
// ****************************************
`define BDR_SRAM_M0 32'h00000000
`define BDR_SRAM_M1 32'h00400000
`define BDR_FLASH_M0 32'h01000000
`define BDR_FLASH_M1 32'h01400000
`define BDR_MEM_MASK 32'hFFC00000
`define BDR_SDRAM2 32'h02000000
`define BDR_SDRAM2_MASK 32'hFF000000
`define BDR_SERA 32'h03000000
`define BDR_SERB 32'h03000100
`define BDR_SER_MASK 32'hFFFFFF00
`define BDR_USB 32'h03080000
`define BDR_USB_MASK 32'hFFFFFF80
`define BDR_NARROW 32'h03300000
`define BDR_NARROW_MASK 32'hFFFFFF00
`define BDR_WIDE 32'h033C0000
`define BDR_WIDE_MASK 32'hFFFC0000

`endif

// [core/bdr_pkg.sv]
package bdr_pkg;
  typedef logic [3:0] bdr_nib_t;
  typedef enum logic [1:0] {bdr_acc_idle, bdr_acc_stretch, bdr_acc_site} bdr_acc_t;
endpackage

// [core/bdr_rst_stretch.sv]
`timescale 1ns/1ns
module bdr_rst_stretch import bdr_pkg::*; #(
  parameter int HOLD_CYC = 10000000
) (
  // clock and sources
  input wire logic clk,
  input wire logic async_src,
  input wire logic sync_src,
  // stretched reset
  output logic hold_active
);
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic next_active;

  // a source held true keeps the counter parked at zero
  always_comb begin
    next_active = hold_active;
    next_cnt = cnt;
    if (sync_src) begin
      next_active = 1'b1;
      next_cnt = '0;
    end else if (hold_active) begin
      if (cnt == 24'(HOLD_CYC - 1)) begin
        next_active = 1'b0;
      end else begin
        next_cnt = cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or posedge async_src) begin
    if (async_src) begin
      hold_active <= 1'b1;
      cnt <= '0;
    end else begin
      hold_active <= next_active;
      cnt <= next_cnt;
    end
  end
endmodule

// [core/bdr_wdog.sv]
`timescale 1ns/1ns
module bdr_wdog import bdr_pkg::*; #(
  parameter int LIMIT_CYC = 80000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic restart,
  // expiry, one cycle
  output logic expired
);
  logic [26:0] cnt;
  logic [26:0] next_cnt;
  logic next_expired;

  always_comb begin
    next_cnt = cnt;
    next_expired = 1'b0;
    if (!enable || restart) begin
      next_cnt = '0;
    end else if (cnt == 27'(LIMIT_CYC - 1)) begin
      next_expired = 1'b1;
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 27'h0000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule

// [core/bdr_top.sv]
`timescale 1ns/1ns
`include "bdr_cfg.svh"

// What this block does
// - board reset is the OR of power, two active-low external resets, pushbutton and watchdog.
// - an enabled watchdog not restarted within about 1.6 s becomes a reset source.
// - a second enable bit lets the clock chip watchdog expiry act as a reset source.
// - board reset asserts as soon as an external source becomes true, and at the next clock edge for either watchdog expiry.
// - board reset stays asserted about 0.2 s after all sources are false.
// - the same board reset resets the processor, peripherals and all control registers.
// - boot codes 0, 1 and 2 read back from the boot code register as 5, 7 and 13.
// - serial channels and USB are decoded at their bases and each access is stretched to 80 ns, 70 ns rounded up to four clocks.
// - expansion sites are decoded at their bases and their ready lines add wait states.
// - the watchdog restart register is write-only, drops its data, and stretches to 100 ns.
// - in area 0 the external memory select bit chooses burst SRAM or first SDRAM bank.
// - the area 2 SDRAM bank is enabled by the same external memory select bit.
// - burst SRAM decodes at 0x00000000 in map zero and 0x00400000 in map one.
// - area 1 flash decodes at 0x01000000 in map zero and 0x01400000 in map one, byte wide.
// - area 3 holds control registers and peripherals, asynchronous with software waits.
// - addresses count bytes and 32-bit registers sit on multiples of four.
module bdr_top import bdr_pkg::*; #(
  parameter int WDOG_CYC = `BDR_WDOG_CYC,
  parameter int HOLD_CYC = `BDR_HOLD_CYC,
  parameter bit BOOT_REMAP = 1'b1,
  parameter bdr_nib_t BOARD_ID = 4'h1 // arbitrary value
) (
  // clock and power-up reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic power_fail,
  input wire logic ext_reset_n,
  input wire logic host_port_reset_n,
  input wire logic reset_pushbutton,
  input wire logic clock_chip_watchdog_expired,
  // processor configuration
  input wire logic memory_map_one,
  input wire bdr_nib_t boot_code_in,
  // processor external memory bus
  input wire logic [3:0] area_sel_n,
  input wire logic [31:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire bdr_nib_t bus_wdata,
  output bdr_nib_t bus_rdata,
  output logic bus_rdata_oe,
  output logic bus_ready,
  // expansion site ready lines
  input wire logic narrow_site_ready,
  input wire logic wide_site_ready,
  // board reset
  output logic board_reset,
  // device selects
  output logic sram_sel,
  output logic sdram_first_sel,
  output logic sdram_second_sel,
  output logic flash_sel,
  output logic serial_a_sel,
  output logic serial_b_sel,
  output logic usb_sel,
  output logic narrow_site_sel,
  output logic wide_site_sel,
  // control register outputs
  output bdr_nib_t irq4_source_select,
  output bdr_nib_t irq5_source_select,
  output bdr_nib_t irq6_source_select,
  output bdr_nib_t irq7_source_select,
  output bdr_nib_t nonmaskable_source_select,
  output bdr_nib_t expansion_site_reset
);

  // ****************************************
  // declarations
  // ****************************************
  bdr_nib_t watchdog_enable;
  bdr_nib_t system_configuration;
  bdr_nib_t boot_code_readback;
  bdr_nib_t next_wde, next_cfg, next_boot;
  bdr_nib_t next_irq4, next_irq5, next_irq6, next_irq7, next_nmi, next_srst;
  bdr_nib_t next_rdata;
  logic next_oe, next_ready;
  logic strb_q, strb, start, rd_act, wr_act;
  logic [2:0] cnt, next_cnt;
  bdr_acc_t acc, next_acc;
  logic async_src, sync_src, wdog_exp, wdog_restart;
  logic external_memory_select_bit;
  logic ce0, ce1, ce2, ce3, aligned;
  logic hit_sera, hit_serb, hit_usb, hit_narrow, hit_wide;
  logic next_sram, next_sd1, next_sd2, next_flash;
  logic reg_hit;

  // ****************************************
  // reset controller
  // ****************************************
  // external sources act without the clock so reset reaches
  // the board even while the clock is not yet running
  assign async_src = rst | power_fail | !ext_reset_n |
                     !host_port_reset_n | reset_pushbutton;
  assign sync_src = wdog_exp |
                    (watchdog_enable[`BDR_WDE_CHIP_BIT] &
                     clock_chip_watchdog_expired);

  bdr_rst_stretch #(
    .HOLD_CYC(HOLD_CYC)
  ) u_stretch (
    .clk(clk),
    .async_src(async_src),
    .sync_src(sync_src),
    .hold_active(board_reset)
  );

  bdr_wdog #(
    .LIMIT_CYC(WDOG_CYC)
  ) u_wdog (
    .clk(clk),
    .rst(board_reset),
    .enable(watchdog_enable[`BDR_WDE_EN_BIT]),
    .restart(wdog_restart),
    .expired(wdog_exp)
  );

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic in_rgn(logic [31:0] a, logic [31:0] base, logic [31:0] mask);
    in_rgn = (a & mask) == base;
  endfunction

  assign ce0 = !area_sel_n[0];
  assign ce1 = !area_sel_n[1];
  assign ce2 = !area_sel_n[2];
  assign ce3 = !area_sel_n[3];
  assign external_memory_select_bit = system_configuration[`BDR_CFG_EXT_MEM_BIT];
  assign aligned = bus_addr[1:0] == 2'h0;

  assign hit_sera = ce3 && in_rgn(bus_addr, `BDR_SERA, `BDR_SER_MASK);
  assign hit_serb = ce3 && in_rgn(bus_addr, `BDR_SERB, `BDR_SER_MASK);
  assign hit_usb = ce3 && in_rgn(bus_addr, `BDR_USB, `BDR_USB_MASK);
  assign hit_narrow = ce3 && in_rgn(bus_addr, `BDR_NARROW, `BDR_NARROW_MASK);
  assign hit_wide = ce3 && in_rgn(bus_addr, `BDR_WIDE, `BDR_WIDE_MASK);

  always_comb begin
    next_sram = 1'b0;
    next_flash = 1'b0;
    if (memory_map_one) begin
      next_sram = in_rgn(bus_addr, `BDR_SRAM_M1, `BDR_MEM_MASK);
      next_flash = in_rgn(bus_addr, `BDR_FLASH_M1, `BDR_MEM_MASK);
    end else begin
      next_sram = in_rgn(bus_addr, `BDR_SRAM_M0, `BDR_MEM_MASK);
      next_flash = in_rgn(bus_addr, `BDR_FLASH_M0, `BDR_MEM_MASK);
    end
    next_sd1 = ce0 && external_memory_select_bit;
    next_sram = next_sram && ce0 && !external_memory_select_bit;
    next_flash = next_flash && ce1;
    next_sd2 = ce2 && external_memory_select_bit &&
               in_rgn(bus_addr, `BDR_SDRAM2, `BDR_SDRAM2_MASK);
  end

  always_ff @(posedge clk or posedge board_reset) begin
    if (board_reset) begin
      sram_sel <= 1'b0;
      sdram_first_sel <= 1'b0;
      sdram_second_sel <= 1'b0;
      flash_sel <= 1'b0;
      serial_a_sel <= 1'b0;
      serial_b_sel <= 1'b0;
      usb_sel <= 1'b0;
      narrow_site_sel <= 1'b0;
      wide_site_sel <= 1'b0;
    end else begin
      sram_sel <= next_sram;
      sdram_first_sel <= next_sd1;
      sdram_second_sel <= next_sd2;
      flash_sel <= next_flash;
      serial_a_sel <= hit_sera;
      serial_b_sel <= hit_serb;
      usb_sel <= hit_usb;
      narrow_site_sel <= hit_narrow;
      wide_site_sel <= hit_wide;
    end
  end

  // ****************************************
  // access timing
  // ****************************************
  assign rd_act = !bus_rd_n && ce3;
  assign wr_act = !bus_wr_n && ce3;
  assign strb = rd_act || wr_act;
  assign start = strb && !strb_q;
  assign wdog_restart = start && wr_act && aligned &&
                        bus_addr == `BDR_WDR_ADDR;

  always_comb begin
    next_acc = acc;
    next_cnt = cnt;
    next_ready = bus_ready;
    unique case (acc)
      bdr_acc_idle: begin
        next_ready = 1'b1;
        if (start && (hit_sera || hit_serb || hit_usb)) begin
          next_acc = bdr_acc_stretch;
          next_cnt = 3'(`BDR_IO_CYC - 1);
          next_ready = 1'b0;
        end else if (wdog_restart) begin
          next_acc = bdr_acc_stretch;
          next_cnt = 3'(`BDR_WDR_CYC - 1);
          next_ready = 1'b0;
        end else if (start && (hit_narrow || hit_wide)) begin
          next_acc = bdr_acc_site;
          next_ready = hit_narrow ? narrow_site_ready : wide_site_ready;
        end
      end
      bdr_acc_stretch: begin
        if (cnt == 3'h0) begin
          next_acc = bdr_acc_idle;
          next_ready = 1'b1;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      bdr_acc_site: begin
        // the site may hold the strobe beyond the programmed waits
        next_ready = narrow_site_sel ? narrow_site_ready : wide_site_ready;
        if (!strb) begin
          next_acc = bdr_acc_idle;
          next_ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge board_reset) begin
    if (board_reset) begin
      acc <= bdr_acc_idle;
      cnt <= 3'h0;
      bus_ready <= 1'b1;
      strb_q <= 1'b0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      bus_ready <= next_ready;
      strb_q <= strb;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_comb begin
    next_boot = boot_code_in;
    if (BOOT_REMAP) begin
      unique case (boot_code_in)
        `BDR_BOOT_RAW0: next_boot = `BDR_BOOT_OUT0;
        `BDR_BOOT_RAW1: next_boot = `BDR_BOOT_OUT1;
        `BDR_BOOT_RAW2: next_boot = `BDR_BOOT_OUT2;
        default: next_boot = boot_code_in;
      endcase
    end
  end

  always_comb begin
    next_wde = watchdog_enable;
    next_cfg = system_configuration;
    next_irq4 = irq4_source_select;
    next_irq5 = irq5_source_select;
    next_irq6 = irq6_source_select;
    next_irq7 = irq7_source_select;
    next_nmi = nonmaskable_source_select;
    next_srst = expansion_site_reset;
    if (start && wr_act && aligned) begin
      unique case (bus_addr)
        `BDR_WDE_ADDR: next_wde = bus_wdata;
        `BDR_IRQ6_ADDR: next_irq6 = bus_wdata;
        `BDR_IRQ7_ADDR: next_irq7 = bus_wdata;
        `BDR_IRQ45_ADDR: begin
          // both selectors share one address
          next_irq4 = bus_wdata;
          next_irq5 = bus_wdata;
        end
        `BDR_NMI_ADDR: next_nmi = bus_wdata;
        `BDR_SRST_ADDR: next_srst = bus_wdata;
        `BDR_CFG_ADDR: next_cfg = bus_wdata;
        default: next_wde = watchdog_enable; // restart data dropped
      endcase
    end
  end

  // reads of the write-only restart word return zero
  always_comb begin
    reg_hit = 1'b1;
    next_rdata = 4'h0;
    unique case (bus_addr)
      `BDR_WDE_ADDR: next_rdata = watchdog_enable;
      `BDR_IRQ6_ADDR: next_rdata = irq6_source_select;
      `BDR_IRQ7_ADDR: next_rdata = irq7_source_select;
      `BDR_IRQ45_ADDR: next_rdata = irq4_source_select;
      `BDR_NMI_ADDR: next_rdata = nonmaskable_source_select;
      `BDR_SRST_ADDR: next_rdata = expansion_site_reset;
      `BDR_ID_ADDR: next_rdata = BOARD_ID;
      `BDR_BOOT_ADDR: next_rdata = boot_code_readback;
      `BDR_CFG_ADDR: next_rdata = system_configuration;
      default: reg_hit = 1'b0;
    endcase
    next_oe = rd_act && aligned && reg_hit;
    if (!next_oe) begin
      next_rdata = 4'h0;
    end
  end

  always_ff @(posedge clk or posedge board_reset) begin
    if (board_reset) begin
      watchdog_enable <= `BDR_WDE_RST;
      system_configuration <= `BDR_CFG_RST;
      irq4_source_select <= `BDR_IRQ4_RST;
      irq5_source_select <= `BDR_IRQ5_RST;
      irq6_source_select <= `BDR_IRQ6_RST;
      irq7_source_select <= `BDR_IRQ7_RST;
      nonmaskable_source_select <= `BDR_NMI_RST;
      expansion_site_reset <= `BDR_SRST_RST;
      boot_code_readback <= 4'h0;
      bus_rdata <= 4'h0;
      bus_rdata_oe <= 1'b0;
    end else begin
      watchdog_enable <= next_wde;
      system_configuration <= next_cfg;
      irq4_source_select <= next_irq4;
      irq5_source_select <= next_irq5;
      irq6_source_select <= next_irq6;
      irq7_source_select <= next_irq7;
      nonmaskable_source_select <= next_nmi;
      expansion_site_reset <= next_srst;
      boot_code_readback <= next_boot;
      bus_rdata <= next_rdata;
      bus_rdata_oe <= next_oe;
    end
  end

endmodule

// [testbench/bdr_top_sva.sv]
`timescale 1ns/1ns
`include "bdr_cfg.svh"
module bdr_top_sva import bdr_pkg::*; #(
  parameter int HOLD_CYC = 50
) (
  // clock and sources
  input wire logic clk,
  input wire logic rst,
  input wire logic power_fail,
  input wire logic ext_reset_n,
  input wire logic host_port_reset_n,
  input wire logic reset_pushbutton,
  input wire bdr_nib_t boot_code_in,
  // bus
  input wire logic [3:0] area_sel_n,
  input wire logic [31:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire bdr_nib_t bus_rdata,
  input wire logic bus_rdata_oe,
  input wire logic bus_ready,
  input wire logic narrow_site_ready,
  // results
  input wire logic board_reset,
  input wire logic usb_sel,
  input wire logic narrow_site_sel,
  input wire bdr_nib_t irq4_source_select,
  input wire bdr_nib_t irq5_source_select,
  input wire bdr_nib_t irq6_source_select,
  input wire bdr_nib_t irq7_source_select,
  input wire bdr_nib_t nonmaskable_source_select,
  input wire bdr_nib_t expansion_site_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic src;
  logic io3;
  int quiet;
  assign src = power_fail | ~ext_reset_n | ~host_port_reset_n | reset_pushbutton;
  assign io3 = ~area_sel_n[3] & ~board_reset;
  // quiet counts edges since the last external source; saturates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) quiet <= 0;
    else if (src) quiet <= 0;
    else if (quiet < HOLD_CYC) quiet <= quiet + 1;
  end
  function automatic bdr_nib_t boot_map(input bdr_nib_t c);
    return c == 4'h0 ? 4'h5 : c == 4'h1 ? 4'h7 : c == 4'h2 ? 4'hD : c;
  endfunction
  property p_src;
    src |-> board_reset;
  endproperty
  a_src: assert property (p_src) else $error("board reset low with source active");
  property p_hold;
    $fell(board_reset) |-> quiet >= HOLD_CYC - 2;
  endproperty
  a_hold: assert property (p_hold) else $error("board reset released too early");
  property p_clear;
    board_reset |-> !bus_rdata_oe && bus_ready && !usb_sel && !narrow_site_sel;
  endproperty
  a_clear: assert property (p_clear) else $error("bus outputs active in reset");
  property p_regs;
    board_reset |-> irq6_source_select == 4'h0 && irq7_source_select == 4'h2
      && irq4_source_select == 4'h4 && irq5_source_select == 4'h5
      && nonmaskable_source_select == 4'hF && expansion_site_reset == 4'h0;
  endproperty
  a_regs: assert property (p_regs) else $error("register not at default in reset");
  property p_ser;
    $fell(bus_rd_n) && io3 && (bus_addr & `BDR_SER_MASK) == `BDR_SERA
      |=> !bus_ready [*4] ##1 bus_ready;
  endproperty
  a_ser: assert property (p_ser) else $error("serial access stretch wrong");
  property p_wdr;
    $fell(bus_wr_n) && io3 && bus_addr == `BDR_WDR_ADDR |=> !bus_ready [*5] ##1 bus_ready;
  endproperty
  a_wdr: assert property (p_wdr) else $error("restart write stretch wrong");
  property p_nowdr;
    !bus_rd_n && io3 && bus_addr == `BDR_WDR_ADDR |=> !bus_rdata_oe;
  endproperty
  a_nowdr: assert property (p_nowdr) else $error("restart register answered a read");
  property p_boot;
    !bus_rd_n && io3 && bus_addr == `BDR_BOOT_ADDR && $stable(boot_code_in)
      |=> bus_rdata_oe && bus_rdata == boot_map($past(boot_code_in));
  endproperty
  a_boot: assert property (p_boot) else $error("boot code readback wrong");
  property p_narrow;
    narrow_site_sel && !bus_rd_n && !narrow_site_ready && $stable(bus_addr) |=> !bus_ready;
  endproperty
  a_narrow: assert property (p_narrow) else $error("site not ready but bus ready");
endmodule
bind bdr_top bdr_top_sva #(.HOLD_CYC(HOLD_CYC)) u_sva (.*);

// [testbench/bdr_dsp_model.sv]
`timescale 1ns/1ns
module bdr_dsp_model import bdr_pkg::*; (
  // clock and answers
  input wire logic clk,
  input wire logic bus_ready,
  input wire bdr_nib_t bus_rdata,
  input wire logic bus_rdata_oe,
  // request
  output logic [3:0] area_sel_n,
  output logic [31:0] bus_addr,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output bdr_nib_t bus_wdata
);
  initial begin
    area_sel_n = 4'hF;
    bus_addr = 32'h0;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_wdata = 4'h0;
  end
  // strobe held until ready is seen high, never before the second edge
  task automatic xfer(input bit rd, input int ar, input logic [31:0] a, input bdr_nib_t d,
                      output int w, output bdr_nib_t q, output logic oe);
    int k;
    k = 0;
    w = 0;
    @(negedge clk);
    area_sel_n = ~(4'h1 << ar);
    bus_addr = a;
    bus_wdata = d;
    bus_rd_n = ~rd;
    bus_wr_n = rd;
    do begin
      @(posedge clk);
      k++;
      if (bus_ready !== 1'b1) w++;
    end while ((k < 2 || bus_ready !== 1'b1) && k < 64);
    q = bus_rdata;
    oe = bus_rdata_oe;
    @(negedge clk);
    area_sel_n = 4'hF;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    // released lines do not keep their last value
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
endmodule

// [testbench/board_io_decode_reset_tb.sv]
`timescale 1ns/1ns
`include "bdr_cfg.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module board_io_decode_reset_tb import bdr_pkg::*; ;
  localparam int HOLD = 50;
  localparam int WDOG = 200;
  typedef struct {int ar; logic [31:0] a; logic xm; logic m1; logic [8:0] sel; int w;} bdr_dec_t;
  logic clk = 1'b0, rst = 1'b1, power_fail = 1'b0, ext_reset_n = 1'b1, host_port_reset_n = 1'b1;
  logic reset_pushbutton = 1'b0, clock_chip_watchdog_expired = 1'b0, memory_map_one = 1'b0;
  logic narrow_site_ready = 1'b1, wide_site_ready = 1'b1, oe, oe_d;
  bdr_nib_t boot_code_in = 4'h0, bus_wdata, bus_rdata, q, v, mv, exp_q[$];
  bdr_nib_t irq4_source_select, irq5_source_select, irq6_source_select, irq7_source_select;
  bdr_nib_t nonmaskable_source_select, expansion_site_reset;
  logic [3:0] area_sel_n;
  logic [31:0] bus_addr;
  logic bus_rd_n, bus_wr_n, bus_rdata_oe, bus_ready, board_reset, sram_sel, sdram_first_sel;
  logic sdram_second_sel, flash_sel, serial_a_sel, serial_b_sel, usb_sel, narrow_site_sel;
  logic wide_site_sel;
  logic [8:0] sel_v;
  integer seed = 32'hA3503CD2;
  int bad_count = 0, tests_run = 0, w, i, n;
  logic [31:0] ra[7] = '{`BDR_WDE_ADDR, `BDR_IRQ6_ADDR, `BDR_IRQ7_ADDR, `BDR_IRQ45_ADDR,
    `BDR_NMI_ADDR, `BDR_SRST_ADDR, `BDR_CFG_ADDR};
  bdr_nib_t rv[7] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'hF, 4'h0, 4'h0};
  bdr_dec_t dc[11] = '{'{0, 32'h0, 0, 0, 9'h100, 0}, '{0, 32'h00400000, 0, 1, 9'h100, 0},
    '{0, 32'h0, 1, 0, 9'h080, 0}, '{2, 32'h02000000, 1, 0, 9'h040, 0},
    '{1, 32'h01000000, 0, 0, 9'h020, 0}, '{1, 32'h01400000, 0, 1, 9'h020, 0},
    '{3, 32'h03000000, 0, 0, 9'h010, 4}, '{3, 32'h03000100, 0, 0, 9'h008, 4},
    '{3, 32'h03080000, 0, 0, 9'h004, 4}, '{3, 32'h03300000, 0, 0, 9'h002, 0},
    '{3, 32'h033C0000, 0, 0, 9'h001, 0}};
  always #10 clk = ~clk;
  assign sel_v = {sram_sel, sdram_first_sel, sdram_second_sel, flash_sel, serial_a_sel,
    serial_b_sel, usb_sel, narrow_site_sel, wide_site_sel};
  bdr_top #(.WDOG_CYC(WDOG), .HOLD_CYC(HOLD)) uut (.*);
  bdr_dsp_model dsp (.*);
  // ********
  // helpers
  // ********
  task automatic rd(input logic [31:0] a, input bdr_nib_t e);
    exp_q.push_back(e);
    dsp.xfer(1, 3, a, 4'h0, w, q, oe);
  endtask
  task automatic rdz(input logic [31:0] a);
    dsp.xfer(1, 3, a, 4'h0, w, q, oe);
    `CHK(oe, 1'b0)
  endtask
  task automatic wr(input logic [31:0] a, input bdr_nib_t d);
    dsp.xfer(0, 3, a, d, w, q, oe);
  endtask
  task automatic ticks(input int c);
    repeat (c) @(negedge clk);
  endtask
  // bounded, a stuck reset is caught by the count check in the external source loop
  task automatic wait_rel;
    n = 0;
    while (board_reset !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask
  function automatic bdr_nib_t boot_map(input bdr_nib_t c);
    return c == 4'h0 ? 4'h5 : c == 4'h1 ? 4'h7 : c == 4'h2 ? 4'hD : c;
  endfunction
  task automatic complete_run;
    `CHK(exp_q.size(), 0)
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // read data checked against the oldest note at each new answer
  always @(negedge clk) begin
    if (bus_rdata_oe === 1'b1 && oe_d !== 1'b1) begin
      mv = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hX;
      `CHK(bus_rdata, mv)
    end
    oe_d = bus_rdata_oe;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run;
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    wait_rel;
    foreach (ra[j]) rd(ra[j], rv[j]);
    rdz(`BDR_WDR_ADDR);
    rdz(32'h03200010);
    rdz(32'h03100006);
    $display("reset values done");
    for (i = 1; i < 7; i++) begin
      v = 4'($random(seed));
      wr(ra[i], v);
      rd(ra[i], v);
      if (i == 3) `CHK(irq5_source_select, v)
    end
    wr(`BDR_ID_ADDR, 4'hE);
    rd(`BDR_ID_ADDR, 4'h1);
    wr(`BDR_WDR_ADDR, 4'hF);
    `CHK(w, 5)
    for (i = 0; i < 8; i++) begin
      boot_code_in = (i < 4) ? i[3:0] : 4'($random(seed));
      ticks(2);
      rd(`BDR_BOOT_ADDR, boot_map(boot_code_in));
    end
    $display("registers done");
    foreach (dc[j]) begin
      wr(`BDR_CFG_ADDR, {3'h0, dc[j].xm});
      memory_map_one = dc[j].m1;
      dsp.xfer(1, dc[j].ar, dc[j].a, 4'h0, w, q, oe);
      `CHK(sel_v, dc[j].sel)
      `CHK(w, dc[j].w)
    end
    for (i = 0; i < 2; i++) begin
      {wide_site_ready, narrow_site_ready} = i ? 2'b01 : 2'b10;
      fork
        dsp.xfer(1, 3, i ? `BDR_WIDE : `BDR_NARROW, 4'h0, w, q, oe);
        begin
          ticks(6);
          {wide_site_ready, narrow_site_ready} = 2'b11;
        end
      join
      `CHK(w >= 4 && w < 8, 1'b1)
    end
    $display("decode done");
    for (i = 0; i < 5; i++) begin
      wr(`BDR_IRQ6_ADDR, 4'hA);
      {rst, power_fail, ext_reset_n, host_port_reset_n, reset_pushbutton} = 5'h06 ^ (5'h10 >> i);
      #1 `CHK(board_reset, 1'b1)
      @(negedge clk);
      {rst, power_fail, ext_reset_n, host_port_reset_n, reset_pushbutton} = 5'h06;
      ticks(HOLD - 3);
      `CHK(board_reset, 1'b1)
      wait_rel;
      `CHK(n < 6, 1'b1)
      rd(`BDR_IRQ6_ADDR, 4'h0);
    end
    wr(`BDR_WDE_ADDR, 4'h1);
    for (i = 0; i < 4; i++) begin
      ticks(WDOG / 2);
      wr(`BDR_WDR_ADDR, 4'($random(seed)));
    end
    `CHK(board_reset, 1'b0)
    n = 0;
    while (board_reset !== 1'b1 && n < 2 * WDOG) begin
      @(negedge clk);
      n++;
    end
    `CHK(n > WDOG - 20 && n <= WDOG + 5, 1'b1)
    wait_rel;
    ticks(WDOG + 20);
    `CHK(board_reset, 1'b0)
    for (i = 0; i < 2; i++) begin
      wr(`BDR_WDE_ADDR, i ? 4'h0 : 4'h2);
      clock_chip_watchdog_expired = 1'b1;
      ticks(2);
      clock_chip_watchdog_expired = 1'b0;
      `CHK(board_reset, i ? 1'b0 : 1'b1)
      wait_rel;
    end
    $display("reset sources done");
    complete_run;
  end
endmodule
